// >>> addressing_mode_prebyte_decoder.sv
// instruction fetch, prebyte handling and addressing-mode decode
//
// Contract
// RL1: inherent instructions are one byte, the opcode alone.
// RL2: immediate takes the byte after the opcode as literal operand.
// RL3: short direct fetches one address byte, address 00 to FF.
// RL4: long direct fetches a 16-bit address from two following bytes.
// RL5: indexed without offset uses the index register alone, 00 to FF.
// RL6: short indexed adds one unsigned offset byte to X or Y.
// RL7: long indexed adds a two-byte offset to the index register.
// RL8: short indirect reads a one-byte operand address via a pointer byte.
// RL9: long indirect forms read a 16-bit pointer from memory.
// RL10: indirect indexed address is index plus fetched pointer, unsigned.
// RL11: short indirect indexed adds index to a one-byte pointer, up to 1FE.
// RL12: relative mode adds a signed 8-bit offset to the program counter.
// RL13: relative direct takes the offset from the byte after the opcode.
// RL14: exactly 63 instruction numbers are decoded.
// RL15: instructions of one to four bytes including prebyte are fetched.
// RL16: one of three prebytes may precede the opcode, then zero to two bytes follow.
// RL17: prebyte 90 switches X-based inherent, immediate, direct, indexed to Y.
// RL18: prebyte 92 turns direct, bit direct, direct relative into indirect.
// RL19: prebyte 91 switches X indirect indexed to Y.
// RL20: a byte neither opcode nor prebyte triggers a reset.
// RL21: valid prebyte with valid opcode in bad combination gives no reset.
// RL22: branch target counts from the address after the branch, -128..+127.
// RL23: relative indirect fetches the signed offset through a short pointer.
`timescale 1ns/1ps
`include "addr_decode_map.svh"

module addressing_mode_prebyte_decoder
    import addr_decode_pkg::*;
#(
    parameter logic [15:0] START_ADDR = `START_PC
)(
    input  wire logic         mclk,
    input  wire logic         rst_n,
    // program memory read port
    output logic              mem_req,
    output logic [15:0]       mem_addr,
    input  wire logic [7:0]   mem_rdata,
    input  wire logic         mem_ack,
    // execution datapath
    input  wire logic [7:0]   x_reg,
    input  wire logic [7:0]   y_reg,
    output logic              dec_valid,
    output decoded_t          dec,
    input  wire logic         exec_done,
    input  wire logic         branch_taken,
    input  wire logic         jump_valid,
    input  wire logic [15:0]  jump_addr,
    output logic [15:0]       pc,
    output logic              illegal_reset
);

    // -------------------------------------------------------------------------
    // state
    // -------------------------------------------------------------------------
    fetch_state_t state;
    logic [7:0]   opcode;
    logic [7:0]   prebyte;
    logic [5:0]   instr_id;
    conv_t        conv;
    logic [1:0]   need;
    logic [1:0]   cnt;
    logic         ptr_cnt;
    logic [15:0]  word;
    logic [7:0]   rel;

    mode_t        base_mode;
    logic         is_prebyte;
    logic         legal;
    logic [5:0]   cls_id;
    conv_t        next_conv;
    logic [15:0]  ea;
    logic         last_opnd;
    logic [7:0]   ptr_byte;

    // -------------------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------------------
    function automatic logic [1:0] addr_bytes(input mode_t m);
        unique case (m)
            mode_inherent,
            mode_indexed_none:   addr_bytes = 2'd0;  // see RL1 RL5
            mode_direct_long,
            mode_indexed_long,
            mode_bit_relative,
            mode_bit_ind_rel:    addr_bytes = 2'd2;  // see RL4 RL7
            default:             addr_bytes = 2'd1;  // see RL2 RL3 RL6 RL8 RL9 RL13
        endcase
    endfunction

    function automatic logic via_pointer(input mode_t m);
        via_pointer = m inside {mode_indirect_short, mode_indirect_long,
                      mode_ind_index_short, mode_ind_index_long,
                      mode_relative_ind, mode_bit_indirect, mode_bit_ind_rel};
    endfunction

    function automatic logic long_pointer(input mode_t m);
        long_pointer = (m == mode_indirect_long) || (m == mode_ind_index_long);
    endfunction

    // bad pairing: plain mode, flag only
    function automatic conv_t apply_prebyte(input logic [7:0] pre, input mode_t m);
        conv_t c;
        c.mode        = m;
        c.use_y       = 1'b0;
        c.unsupported = 1'b0;
        unique case (pre)
            `PRE_Y_INDEX: begin
                if (m == mode_inherent || m == mode_immediate || m == mode_direct_short ||
                    m == mode_direct_long || m == mode_indexed_none ||
                    m == mode_indexed_short || m == mode_indexed_long) begin
                    c.use_y = 1'b1;  // see RL17
                end else begin
                    c.unsupported = 1'b1;  // see RL21
                end
            end
            `PRE_Y_INDIRECT: begin
                c.use_y = 1'b1;  // see RL19
                if (m == mode_indexed_short) begin
                    c.mode = mode_ind_index_short;
                end else if (m == mode_indexed_long) begin
                    c.mode = mode_ind_index_long;
                end else begin
                    c.use_y       = 1'b0;
                    c.unsupported = 1'b1;  // see RL21
                end
            end
            `PRE_INDIRECT: begin
                unique case (m)  // see RL18
                    mode_direct_short:  c.mode = mode_indirect_short;
                    mode_direct_long:   c.mode = mode_indirect_long;
                    mode_indexed_short: c.mode = mode_ind_index_short;
                    mode_indexed_long:  c.mode = mode_ind_index_long;
                    mode_relative:      c.mode = mode_relative_ind;
                    mode_bit_direct:    c.mode = mode_bit_indirect;
                    mode_bit_relative:  c.mode = mode_bit_ind_rel;
                    default:            c.unsupported = 1'b1;  // see RL21
                endcase
            end
            default: ;
        endcase
        return c;
    endfunction

    // -------------------------------------------------------------------------
    // submodules
    // -------------------------------------------------------------------------
    opcode_classifier u_classifier (
        .code       (mem_rdata),
        .base_mode  (base_mode),
        .is_prebyte (is_prebyte),
        .legal      (legal),
        .instr_id   (cls_id)
    );

    ea_adder u_ea (
        .mode  (conv.mode),
        .index (conv.use_y ? y_reg : x_reg),
        .word  (word),
        .ea    (ea)
    );

    assign next_conv = apply_prebyte(prebyte, base_mode);
    assign last_opnd = (cnt + 2'd1 == need);
    // bit-relative: address byte first
    assign ptr_byte  = (cnt == 2'd0) ? mem_rdata : word[7:0];

    assign mem_req   = (state == st_opcode) || (state == st_operand) ||
                       (state == st_pointer);
    assign dec_valid = (state == st_issue);

    // -------------------------------------------------------------------------
    // fetch sequencer
    // -------------------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state    <= st_opcode;
            pc       <= `START_PC;
            mem_addr <= `START_PC;
            prebyte  <= `PRE_NONE;
            opcode   <= 8'h00;
            instr_id <= 6'h00;
            conv     <= '0;
            need     <= 2'd0;
            cnt      <= 2'd0;
            ptr_cnt  <= 1'b0;
            word     <= 16'h0000;
            rel      <= 8'h00;
        end else begin
            unique case (state)
                st_opcode: begin
                    if (mem_ack) begin
                        if (is_prebyte) begin
                            prebyte  <= mem_rdata;  // see RL16
                            pc       <= pc + 16'h0001;
                            mem_addr <= pc + 16'h0001;
                        end else if (!legal) begin
                            prebyte  <= `PRE_NONE;  // see RL20
                            pc       <= START_ADDR;
                            mem_addr <= START_ADDR;
                        end else begin
                            opcode   <= mem_rdata;
                            instr_id <= cls_id;
                            conv     <= next_conv;
                            need     <= addr_bytes(next_conv.mode);
                            cnt      <= 2'd0;
                            word     <= 16'h0000;
                            rel      <= 8'h00;
                            pc       <= pc + 16'h0001;
                            mem_addr <= pc + 16'h0001;
                            state    <= (addr_bytes(next_conv.mode) == 2'd0) ?
                                        st_calc : st_operand;  // see RL1
                        end
                    end
                end
                st_operand: begin
                    if (mem_ack) begin
                        if (conv.mode == mode_relative ||
                            ((conv.mode == mode_bit_relative || conv.mode == mode_bit_ind_rel)
                             && cnt == 2'd1)) begin
                            rel <= mem_rdata;  // see RL13
                        end else if (need == 2'd2 && cnt == 2'd0 &&
                                     conv.mode < mode_bit_relative) begin
                            word[15:8] <= mem_rdata;  // see RL4 RL7
                        end else begin
                            word[7:0] <= mem_rdata;  // see RL2 RL3 RL6
                        end
                        cnt      <= cnt + 2'd1;
                        pc       <= pc + 16'h0001;
                        mem_addr <= pc + 16'h0001;
                        if (last_opnd) begin
                            if (via_pointer(conv.mode)) begin
                                mem_addr <= {`PAGE_ZERO, ptr_byte};  // see RL8 RL9
                                ptr_cnt  <= 1'b0;
                                state    <= st_pointer;
                            end else begin
                                state <= st_calc;
                            end
                        end
                    end
                end
                st_pointer: begin
                    if (mem_ack) begin
                        if (long_pointer(conv.mode) && !ptr_cnt) begin
                            word[15:8] <= mem_rdata;  // see RL9
                            ptr_cnt    <= 1'b1;
                            mem_addr   <= mem_addr + 16'h0001;
                        end else begin
                            if (conv.mode == mode_relative_ind) begin
                                rel <= mem_rdata;  // see RL23
                            end else if (long_pointer(conv.mode)) begin
                                word[7:0] <= mem_rdata;  // see RL10
                            end else begin
                                word <= {`PAGE_ZERO, mem_rdata};  // see RL8 RL11
                            end
                            state <= st_calc;
                        end
                    end
                end
                st_calc: begin
                    state <= st_issue;
                end
                st_issue: begin
                    if (exec_done) begin
                        if (jump_valid) begin
                            pc       <= jump_addr;
                            mem_addr <= jump_addr;
                        end else if (branch_taken) begin
                            pc       <= dec.branch_target;  // see RL12
                            mem_addr <= dec.branch_target;
                        end else begin
                            mem_addr <= pc;
                        end
                        prebyte <= `PRE_NONE;
                        state   <= st_opcode;
                    end
                end
                default: state <= st_opcode;
            endcase
        end
    end

    // -------------------------------------------------------------------------
    // decoded instruction
    // -------------------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            dec <= '0;
        end else if (state == st_calc) begin
            dec.opcode      <= opcode;
            dec.prebyte     <= prebyte;
            dec.instr_id    <= instr_id;
            dec.mode        <= conv.mode;
            dec.use_y       <= conv.use_y;
            dec.unsupported <= conv.unsupported;
            // prebyte, opcode, 0 to 2 bytes
            dec.length      <= 3'(need) + ((prebyte != `PRE_NONE) ? 3'h2 : 3'h1);  // see RL15
            dec.operand     <= word[7:0];
            dec.ea          <= ea;
            dec.rel_offset  <= rel;
            // pc is past the instruction here
            dec.branch_target <= pc + {{8{rel[7]}}, rel};  // see RL22 RL12
        end
    end

    // -------------------------------------------------------------------------
    // illegal code reset request
    // -------------------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            illegal_reset <= 1'b0;
        end else begin
            illegal_reset <= (state == st_opcode) && mem_ack && !is_prebyte &&
                             !legal;  // see RL20 RL21
        end
    end

endmodule // addressing_mode_prebyte_decoder

// >>> addr_decode_map.svh
// constants of the instruction fetch and decode logic
`ifndef ADDR_DECODE_MAP_SVH
`define ADDR_DECODE_MAP_SVH

// -----------------------------------------------------------------------------
// prebyte codes
// -----------------------------------------------------------------------------
`define PRE_NONE            8'h00
`define PRE_Y_INDEX         8'h90
`define PRE_Y_INDIRECT      8'h91
`define PRE_INDIRECT        8'h92

// -----------------------------------------------------------------------------
// opcode layout and limits
// -----------------------------------------------------------------------------
`define OPC_MODE_HI         7
`define OPC_MODE_LO         4
`define OPC_ID_HI           5
`define OPC_ID_LO           0
`define INSTR_COUNT         6'h3f
`define PREBYTE_ROW         4'h9
`define MAX_INSTR_LEN       3'h4

// -----------------------------------------------------------------------------
// reset value and zero-page high byte
// -----------------------------------------------------------------------------
`define START_PC            16'h0000
`define PAGE_ZERO           8'h00

`endif

// >>> addr_decode_pkg.sv
// types shared by the instruction fetch and decode logic
package addr_decode_pkg;

    typedef enum logic [4:0] {
        mode_inherent        = 5'h00,
        mode_immediate       = 5'h01,
        mode_direct_short    = 5'h02,
        mode_direct_long     = 5'h03,
        mode_indexed_none    = 5'h04,
        mode_indexed_short   = 5'h05,
        mode_indexed_long    = 5'h06,
        mode_indirect_short  = 5'h07,
        mode_indirect_long   = 5'h08,
        mode_ind_index_short = 5'h09,
        mode_ind_index_long  = 5'h0a,
        mode_relative        = 5'h0b,
        mode_relative_ind    = 5'h0c,
        mode_bit_direct      = 5'h0d,
        mode_bit_indirect    = 5'h0e,
        mode_bit_relative    = 5'h0f,
        mode_bit_ind_rel     = 5'h10
    } mode_t;

    typedef enum logic [2:0] {
        st_opcode  = 3'h0,
        st_operand = 3'h1,
        st_pointer = 3'h2,
        st_calc    = 3'h3,
        st_issue   = 3'h4
    } fetch_state_t;

    typedef struct packed {
        mode_t      mode;
        logic       use_y;
        logic       unsupported;
    } conv_t;

    typedef struct packed {
        logic [7:0]  opcode;
        logic [7:0]  prebyte;
        logic [5:0]  instr_id;
        mode_t       mode;
        logic        use_y;
        logic        unsupported;
        logic [2:0]  length;
        logic [7:0]  operand;
        logic [15:0] ea;
        logic [7:0]  rel_offset;
        logic [15:0] branch_target;
    } decoded_t;

endpackage

// >>> opcode_classifier.sv
// classifies a fetched byte as prebyte, legal opcode or illegal code
`timescale 1ns/1ps
`include "addr_decode_map.svh"

module opcode_classifier
    import addr_decode_pkg::*;
(
    input  wire logic [7:0] code,
    output mode_t           base_mode,
    output logic            is_prebyte,
    output logic            legal,
    output logic [5:0]      instr_id
);

    logic [3:0] row;
    logic       row_ok;

    assign row      = code[`OPC_MODE_HI:`OPC_MODE_LO];
    assign instr_id = code[`OPC_ID_HI:`OPC_ID_LO];

    // indirect forms come by prebyte only
    always_comb begin
        row_ok    = 1'b1;
        base_mode = mode_inherent;
        unique case (row)
            4'h0: base_mode = mode_inherent;
            4'h1: base_mode = mode_immediate;
            4'h2: base_mode = mode_direct_short;
            4'h3: base_mode = mode_direct_long;
            4'h4: base_mode = mode_indexed_none;
            4'h5: base_mode = mode_indexed_short;
            4'h6: base_mode = mode_indexed_long;
            4'hc: base_mode = mode_relative;
            4'hd: base_mode = mode_bit_direct;
            4'he: base_mode = mode_bit_relative;
            default: row_ok = 1'b0;
        endcase
    end

    assign is_prebyte = (code == `PRE_Y_INDEX) || (code == `PRE_Y_INDIRECT) ||  // see RL16
                        (code == `PRE_INDIRECT);
    // id 3f left undefined: 63 ids over all rows, 16 codes a row
    assign legal      = row_ok && (instr_id != `INSTR_COUNT);  // see RL14

endmodule // opcode_classifier

// >>> ea_adder.sv
// effective address former; inherent, immediate, relative and relative indirect modes give 0000
`timescale 1ns/1ps
`include "addr_decode_map.svh"

module ea_adder
    import addr_decode_pkg::*;
(
    input  mode_t             mode,
    input  wire logic [7:0]   index,
    input  wire logic [15:0]  word,
    output logic [15:0]       ea
);

    logic [15:0] index_wide;

    assign index_wide = {`PAGE_ZERO, index};

    always_comb begin
        ea = 16'h0000;
        unique case (mode)
            mode_indexed_none:    ea = index_wide;                            // see RL5
            mode_indexed_short:   ea = index_wide + {`PAGE_ZERO, word[7:0]};  // see RL6
            mode_indexed_long:    ea = index_wide + word;                     // see RL7
            mode_ind_index_short: ea = index_wide + {`PAGE_ZERO, word[7:0]};  // see RL11
            mode_ind_index_long:  ea = index_wide + word;                     // see RL10
            mode_direct_short,
            mode_indirect_short,
            mode_bit_direct,
            mode_bit_indirect,
            mode_bit_relative,
            mode_bit_ind_rel:     ea = {`PAGE_ZERO, word[7:0]};   // see RL3 RL8
            mode_direct_long,
            mode_indirect_long:   ea = word;                      // see RL4 RL9
            default:              ea = 16'h0000;
        endcase
    end

endmodule // ea_adder

// >>> decoder_assertions.sv
// concurrent checks on the fetch and decode ports
`timescale 1ns/1ps
module decoder_assertions
    import addr_decode_pkg::*;
#(
    parameter logic [15:0] START_ADDR = 16'h0000
)(
    input logic        mclk,
    input logic        rst_n,
    input logic        mem_req,
    input logic [15:0] mem_addr,
    input logic [7:0]  mem_rdata,
    input logic        mem_ack,
    input logic [7:0]  x_reg,
    input logic [7:0]  y_reg,
    input logic        dec_valid,
    input decoded_t    dec,
    input logic        exec_done,
    input logic        branch_taken,
    input logic        jump_valid,
    input logic [15:0] jump_addr,
    input logic [15:0] pc,
    input logic        illegal_reset
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    function automatic logic bad(input logic [7:0] b);
        return b[7:4] inside {4'h7, 4'h8, 4'ha, 4'hb, 4'hf} || b[5:0] == 6'h3f
            || (b[7:4] == 4'h9 && !(b inside {8'h90, 8'h91, 8'h92}));
    endfunction

    addr_hold_a: assert property (mem_req && !mem_ack |=> $stable(mem_addr))
        else $error("fetch address moved");
    illegal_cause_a: assert property (illegal_reset |-> $past(mem_ack) && bad($past(mem_rdata)))
        else $error("needless reset");
    restart_pulse_a: assert property (illegal_reset |-> mem_addr == START_ADDR && pc == START_ADDR
        ##1 !illegal_reset)
        else $error("bad restart");
    dec_hold_a: assert property (dec_valid && !exec_done |=> dec_valid && $stable(dec))
        else $error("decode not held");
    retire_fetch_a: assert property (dec_valid && exec_done |=> !dec_valid && mem_req)
        else $error("no refetch");
    jump_load_a: assert property (dec_valid && exec_done && jump_valid |=> pc == $past(jump_addr))
        else $error("jump lost");
    branch_load_a: assert property (dec_valid && exec_done && branch_taken && !jump_valid
        |=> pc == $past(dec.branch_target))
        else $error("branch lost");
    rel_target_a: assert property (dec_valid && dec.mode == mode_relative
        |-> dec.branch_target == pc + {{8{dec.rel_offset[7]}}, dec.rel_offset})
        else $error("bad target");
    length_range_a: assert property (dec_valid |-> !mem_req && dec.length inside {[3'h1:3'h4]})
        else $error("bad length");
    inherent_len_a: assert property (dec_valid && dec.mode == mode_inherent
        && dec.prebyte == 8'h00 |-> dec.length == 3'h1)
        else $error("inherent length");
    page_zero_a: assert property (dec_valid && dec.mode inside {mode_direct_short,
        mode_indirect_short} |-> dec.ea[15:8] == 8'h00)
        else $error("not page zero");
    idx_plain_a: assert property (dec_valid && dec.mode == mode_indexed_none
        |-> dec.ea == {8'h00, dec.use_y ? y_reg : x_reg})
        else $error("bad indexed address");

    cover property (illegal_reset);
    cover property (dec_valid && exec_done && branch_taken);
    cover property (mem_req && !mem_ack ##1 mem_ack);
endmodule // decoder_assertions

bind addressing_mode_prebyte_decoder decoder_assertions #(.START_ADDR(START_ADDR))
    decoder_assertions_inst (.mclk, .rst_n, .mem_req, .mem_addr, .mem_rdata, .mem_ack,
    .x_reg, .y_reg, .dec_valid, .dec, .exec_done, .branch_taken, .jump_valid,
    .jump_addr, .pc, .illegal_reset);

// >>> prog_mem.sv
// program memory model answering byte reads, optionally with wait cycles
`timescale 1ns/1ps
module prog_mem (
    input  logic        mclk,
    input  logic        slow,
    input  logic        mem_req,
    input  logic [15:0] mem_addr,
    output logic [7:0]  mem_rdata,
    output logic        mem_ack
);
    logic [7:0] mem [0:65535];
    logic       gap;

    initial begin
        mem_ack = 1'b0;
        mem_rdata = 8'h00;
        gap = 1'b0;
    end

    // between answers the data line flips, so a stale byte never looks valid
    always @(negedge mclk) begin
        if (mem_req && !(slow && !gap)) begin
            mem_ack <= 1'b1;
            mem_rdata <= mem[mem_addr];
            gap <= 1'b0;
        end else begin
            mem_ack <= 1'b0;
            mem_rdata <= ~mem_rdata;
            gap <= 1'b1;
        end
    end
endmodule // prog_mem

// >>> test_addressing_mode_prebyte_decoder.sv
// self-checking bench for the fetch and decode logic
`timescale 1ns/1ps
module test_addressing_mode_prebyte_decoder;
    import addr_decode_pkg::*;
    logic        mclk = 1'b0;
    logic        rst_n = 1'b0;
    logic        slow = 1'b0;
    logic        exec_done = 1'b0;
    logic        branch_taken = 1'b0;
    logic        jump_valid = 1'b0;
    logic [7:0]  x_reg = 8'hff;
    logic [7:0]  y_reg = 8'h10;
    logic [15:0] jump_addr = 16'h0000;
    logic [15:0] wp = 16'h0000;
    logic        mem_req, mem_ack, dec_valid, illegal_reset;
    logic [7:0]  mem_rdata;
    logic [15:0] mem_addr, pc;
    decoded_t    dec;
    int          fail_count = 0;
    int          n_compared = 0;

    initial begin
        forever #50 mclk = ~mclk;
    end

    addressing_mode_prebyte_decoder addressing_mode_prebyte_decoder_inst (.mclk, .rst_n,
        .mem_req, .mem_addr, .mem_rdata, .mem_ack, .x_reg, .y_reg, .dec_valid, .dec,
        .exec_done, .branch_taken, .jump_valid, .jump_addr, .pc, .illegal_reset);
    prog_mem prog_mem_inst (.mclk, .slow, .mem_req, .mem_addr, .mem_rdata, .mem_ack);

    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // written between model reads
    task automatic put(input logic [7:0] b[$]);
        foreach (b[i]) begin
            prog_mem_inst.mem[wp] = b[i];
            wp++;
        end
    endtask

    task automatic await(ref logic s);
        int n = 0;
        while (s !== 1'b1 && n < 40) begin
            @(negedge mclk);
            n++;
        end
        if (s !== 1'b1) begin
            fail_count++;
            $display("Error wait expected 1 seen timeout");
            results();
        end
    endtask

    task automatic step(input mode_t m, input logic [2:0] len, input logic [15:0] ea = 16'h0000,
                        input logic [1:0] fl = 2'b00, input logic bt = 1'b0, input logic jv = 1'b0,
                        input logic [15:0] tgt = 16'h0000);
        @(negedge mclk);
        rst_n = 1'b1;
        exec_done = 1'b0;
        await(dec_valid);
        chk("mode", 16'(m), 16'(dec.mode));
        chk("length", 16'(len), 16'(dec.length));
        chk("ea", ea, m == mode_immediate ? {8'h00, dec.operand} : dec.ea);
        chk("flags", 16'(fl), 16'({dec.use_y, dec.unsupported}));
        if (m inside {mode_relative, mode_relative_ind}) begin
            chk("target", tgt, dec.branch_target);
        end
        exec_done = 1'b1;
        branch_taken = bt;
        jump_valid = jv;
        jump_addr = tgt;
        @(posedge mclk);
        if (bt || jv) begin
            wp = tgt;
        end
    endtask

    task automatic t_direct();
        slow = 1'b1;
        put({8'h00, 8'h15, 8'h55, 8'h20, 8'h80, 8'h31, 8'h12, 8'h34});
        step(mode_inherent, 3'h1);
        step(mode_immediate, 3'h2, 16'h0055);
        step(mode_direct_short, 3'h2, 16'h0080);
        step(mode_direct_long, 3'h3, 16'h1234, 2'b00, 1'b0, 1'b1, 16'h0200);
        slow = 1'b0;
        $display("test direct done");
    endtask

    task automatic t_indexed();
        put({8'h40, 8'h50, 8'hff, 8'h90, 8'h60, 8'hff, 8'h00});
        step(mode_indexed_none, 3'h1, 16'h00ff);
        step(mode_indexed_short, 3'h2, 16'h01fe);
        step(mode_indexed_long, 3'h4, 16'hff10, 2'b10);
        $display("test indexed done");
    endtask

    task automatic t_indirect();
        logic [15:0] k;
        k = wp;
        wp = 16'h00f0;
        put({8'hab, 8'hff, 8'h12, 8'h34, 8'hfe});
        wp = k;
        put({8'h92, 8'h20, 8'hf0, 8'h92, 8'h30, 8'hf2});
        put({8'h92, 8'h50, 8'hf1, 8'h91, 8'h60, 8'hf2});
        step(mode_indirect_short, 3'h3, 16'h00ab);
        step(mode_indirect_long, 3'h3, 16'h1234);
        step(mode_ind_index_short, 3'h3, 16'h01fe);
        step(mode_ind_index_long, 3'h3, 16'h1244, 2'b10);
        $display("test indirect done");
    endtask

    task automatic t_relative();
        put({8'hc0, 8'h80});
        step(mode_relative, 3'h2, 16'h0000, 2'b00, 1'b1, 1'b0, 16'h0195);
        put({8'hc0, 8'h7f, 8'h92, 8'hc0, 8'hf4});
        step(mode_relative, 3'h2, 16'h0000, 2'b00, 1'b0, 1'b0, 16'h0216);
        step(mode_relative_ind, 3'h3, 16'h0000, 2'b00, 1'b0, 1'b0, 16'h0198);
        $display("test relative done");
    endtask

    task automatic t_illegal();
        put({8'h91, 8'h00, 8'h70});
        step(mode_inherent, 3'h2, 16'h0000, 2'b01);
        @(negedge mclk);
        exec_done = 1'b0;
        await(illegal_reset);
        chk("restart", 16'h0000, mem_addr);
        wp = 16'h0001;
        step(mode_inherent, 3'h1);
        $display("test illegal done");
    endtask

    initial begin
        repeat (6) @(posedge mclk);
        t_direct();
        t_indexed();
        t_indirect();
        t_relative();
        t_illegal();
        results();
    end
endmodule // test_addressing_mode_prebyte_decoder
